// ### rtl/cpl_loop.v
// carrier loop dividers, phase comparator, lock detect and monitor divider
`include "cpl_consts.vh"

// Notes on behaviour
// R01: reference input divided by programmed ratio 4 gives the comparison rate.
// R02: feedback input divided by programmed channel ratio to match comparison rate.
// R03: feedback lagging reference drives pump output high.
// R04: feedback leading reference drives pump output low.
// R05: on lock: lock output high, lamp lit, active-low lock signal low.
// R06: on lock loss: lock output low, lamp dark, unlock reported to controller.
// R07: controller reprograms dividers after an unlock indication.
// R08: controller computes ratios and loads them into the divider registers.
// R09: monitor divider pulses once per 1280 input cycles.
// R10: each monitor pulse toggles a square wave at input rate over 2560.
// R11: lock only after error stays in window for several comparison cycles.
module cpl_loop #(
  parameter CW = 16,
  parameter LOCK_WINDOW = `CPL_LOCK_WINDOW,
  parameter LOCK_COUNT = `CPL_LOCK_COUNT
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire ref_in,
  input wire rf_fb_in,
  input wire rf_mon_in,
  output reg pump_drive_out,
  output reg pump_drive_oe_n,
  output reg lock_detect,
  output reg lock_lamp,
  output reg lock_n,
  output reg divided_pulse_or_lock_out,
  output reg mon_square,
  output wire irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [1:0] ctrl;
  reg [CW-1:0] ref_div;
  reg [CW-1:0] fb_div;
  reg [CW-1:0] mon_div;
  reg [`CPL_IRQ_W-1:0] irq_stat;
  reg [`CPL_IRQ_W-1:0] irq_mask;
  reg restart;
  reg pump_up;
  reg pump_dn;
  reg [CW-1:0] err_cnt;
  reg [CW-1:0] err_last;
  reg [3:0] good_cnt;
  reg locked;
  reg locked_d;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire run;
  wire ref_pulse;
  wire fb_pulse;
  wire mon_pulse;
  wire [CW-1:0] ref_count;
  wire [CW-1:0] fb_count;
  wire [CW-1:0] mon_count;
  wire setup_rd;
  wire wr_en;
  wire lock_gain_ev;
  wire lock_lost_ev;
  wire [`CPL_IRQ_W-1:0] irq_set;
  wire [`CPL_IRQ_W-1:0] irq_clr;
  wire window_ok;
  wire [CW-1:0] lock_window_w;
  wire [3:0] lock_count_w;

  assign run = ctrl[`CPL_CTRL_EN];
  assign lock_window_w = LOCK_WINDOW[CW-1:0];
  assign lock_count_w = LOCK_COUNT[3:0];

  // ---------------------------------------------------------------
  // apb slave: zero wait states, read data captured in setup
  // ---------------------------------------------------------------
  // no wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en = psel & penable & pwrite;

  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `CPL_OFF_CTRL: next_prdata = {30'h0000_0000, ctrl};
      `CPL_OFF_REF_DIV: next_prdata = {{(32-CW){1'b0}}, ref_div};
      `CPL_OFF_FB_DIV: next_prdata = {{(32-CW){1'b0}}, fb_div};
      `CPL_OFF_MON_DIV: next_prdata = {{(32-CW){1'b0}}, mon_div};
      `CPL_OFF_STATUS: next_prdata = {28'h000_0000, mon_square, pump_dn, pump_up, locked};
      `CPL_OFF_IRQ_STAT: next_prdata = {{(32-`CPL_IRQ_W){1'b0}}, irq_stat};
      `CPL_OFF_IRQ_MASK: next_prdata = {{(32-`CPL_IRQ_W){1'b0}}, irq_mask};
      `CPL_OFF_PHASE_ERR: next_prdata = {{(32-CW){1'b0}}, err_last};
      default: next_pslverr = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= setup_rd ? next_prdata : 32'h0000_0000;
      pslverr <= next_pslverr;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control and divider ratio registers
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CPL_RST_CTRL;
      ref_div <= `CPL_RST_REF_DIV;
      fb_div <= `CPL_RST_FB_DIV;
      mon_div <= `CPL_RST_MON_DIV;
      irq_mask <= `CPL_RST_IRQ_MASK;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `CPL_OFF_CTRL: begin
            ctrl[`CPL_CTRL_EN] <= pwdata[`CPL_CTRL_EN];
            // reinit bit is a self-clearing strobe
            restart <= pwdata[`CPL_CTRL_REINIT]; // [R07]
          end
          `CPL_OFF_REF_DIV: begin
            ref_div <= pwdata[CW-1:0]; // [R01]
            restart <= 1'b1;
          end
          `CPL_OFF_FB_DIV: begin
            fb_div <= pwdata[CW-1:0]; // [R02] [R08]
            restart <= 1'b1;
          end
          `CPL_OFF_MON_DIV: begin
            mon_div <= pwdata[CW-1:0]; // [R09]
            restart <= 1'b1;
          end
          `CPL_OFF_IRQ_MASK: irq_mask <= pwdata[`CPL_IRQ_W-1:0];
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  // reference: 200 kHz over 4 gives 50 kHz comparison pulses
  cpl_edge_div #(
    .CW(CW)
  ) u_ref_div (
    .clk(pclk),
    .rst_n(presetn),
    .sig_in(ref_in),
    .run(run),
    .restart(restart),
    .ratio(ref_div),
    .pulse(ref_pulse),
    .count(ref_count)
  ); // [R01]

  // feedback: channel frequency over the channel ratio
  cpl_edge_div #(
    .CW(CW)
  ) u_fb_div (
    .clk(pclk),
    .rst_n(presetn),
    .sig_in(rf_fb_in),
    .run(run),
    .restart(restart),
    .ratio(fb_div),
    .pulse(fb_pulse),
    .count(fb_count)
  ); // [R02]

  // monitor prescaler: programmable ratio, 1280 after reset
  cpl_edge_div #(
    .CW(CW)
  ) u_mon_div (
    .clk(pclk),
    .rst_n(presetn),
    .sig_in(rf_mon_in),
    .run(run),
    .restart(restart),
    .ratio(mon_div),
    .pulse(mon_pulse),
    .count(mon_count)
  ); // [R09]

  // ---------------------------------------------------------------
  // phase-frequency comparator
  // ---------------------------------------------------------------
  // reference edge first: feedback lags, pump up until feedback edge
  // feedback edge first: feedback leads, pump down until reference edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end else if (!run || restart) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end else if (pump_up & pump_dn) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
    end else begin
      if (ref_pulse) begin
        pump_up <= 1'b1; // [R03]
      end
      if (fb_pulse) begin
        pump_dn <= 1'b1; // [R04]
      end
    end
  end

  // tri-state charge pump pin: driven only while one side is active
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_drive_out <= 1'b0;
      pump_drive_oe_n <= 1'b1;
    end else begin
      pump_drive_out <= pump_up & ~pump_dn; // [R03] [R04]
      pump_drive_oe_n <= ~(pump_up ^ pump_dn);
    end
  end

  // ---------------------------------------------------------------
  // lock detector
  // ---------------------------------------------------------------
  // error width counts pclk cycles with exactly one pump side active
  assign window_ok = (err_cnt <= lock_window_w);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= {CW{1'b0}};
      err_last <= {CW{1'b0}};
      good_cnt <= 4'h0;
    end else if (!run || restart) begin
      err_cnt <= {CW{1'b0}};
      err_last <= {CW{1'b0}};
      good_cnt <= 4'h0;
    end else if (ref_pulse) begin
      err_last <= err_cnt;
      err_cnt <= {CW{1'b0}};
      if (!window_ok) begin
        good_cnt <= 4'h0; // [R11]
      end else if (good_cnt != lock_count_w) begin
        good_cnt <= good_cnt + 4'h1; // [R11]
      end
    end else if (pump_up ^ pump_dn) begin
      // missing feedback keeps the pump up and overflows the window
      if (err_cnt != {CW{1'b1}}) begin
        err_cnt <= err_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      // an overrun ends the run of good comparisons, so lock cannot bounce back
      if (!window_ok) begin
        good_cnt <= 4'h0; // [R11]
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
      locked_d <= 1'b0;
    end else begin
      locked_d <= locked;
      if (!run || restart) begin
        locked <= 1'b0;
      end else if ((pump_up ^ pump_dn) && !window_ok) begin
        locked <= 1'b0; // [R06]
      end else begin
        locked <= (good_cnt == lock_count_w); // [R11]
      end
    end
  end

  // lock outputs: detect high and lamp lit on lock, lock_n low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_detect <= 1'b0;
      lock_lamp <= 1'b0;
      lock_n <= 1'b1;
    end else begin
      lock_detect <= locked; // [R05] [R06]
      lock_lamp <= locked; // [R05] [R06]
      lock_n <= ~locked; // [R05]
    end
  end

  // ---------------------------------------------------------------
  // monitor output and square wave
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_pulse_or_lock_out <= 1'b0;
      mon_square <= 1'b0;
    end else begin
      divided_pulse_or_lock_out <= mon_pulse; // [R09]
      if (!run || restart) begin
        mon_square <= 1'b0;
      end else if (mon_pulse) begin
        mon_square <= ~mon_square; // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  assign lock_gain_ev = locked & ~locked_d;
  assign lock_lost_ev = ~locked & locked_d;
  assign irq_set = {lock_lost_ev, lock_gain_ev};
  assign irq_clr = (wr_en && (paddr == `CPL_OFF_IRQ_STAT)) ? pwdata[`CPL_IRQ_W-1:0] : {`CPL_IRQ_W{1'b0}};

  // a new event in the clearing cycle stays set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {`CPL_IRQ_W{1'b0}};
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set; // [R06]
    end
  end

  // unlock reaches the controller through this line
  assign irq = |(irq_stat & irq_mask); // [R06]

endmodule // cpl_loop

// ### rtl/cpl_consts.vh
// constants for the carrier loop divider and lock block
`ifndef CPL_CONSTS_VH
`define CPL_CONSTS_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define CPL_OFF_CTRL 8'h00
`define CPL_OFF_REF_DIV 8'h04
`define CPL_OFF_FB_DIV 8'h08
`define CPL_OFF_MON_DIV 8'h0c
`define CPL_OFF_STATUS 8'h10
`define CPL_OFF_IRQ_STAT 8'h14
`define CPL_OFF_IRQ_MASK 8'h18
`define CPL_OFF_PHASE_ERR 8'h1c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CPL_CTRL_EN 0
`define CPL_CTRL_REINIT 1
`define CPL_ST_LOCKED 0
`define CPL_ST_PUMP_UP 1
`define CPL_ST_PUMP_DN 2
`define CPL_ST_MON_SQ 3
`define CPL_IRQ_LOCK_GAIN 0
`define CPL_IRQ_LOCK_LOST 1
`define CPL_IRQ_W 2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CPL_RST_CTRL 2'h1
`define CPL_RST_REF_DIV 16'h0004
`define CPL_RST_FB_DIV 16'h08d4
`define CPL_RST_MON_DIV 16'h0500
`define CPL_RST_IRQ_MASK 2'h0

// ---------------------------------------------------------------
// lock detector timing counts, in pclk cycles and comparison cycles
// ---------------------------------------------------------------
`define CPL_LOCK_WINDOW 16'h0004
`define CPL_LOCK_COUNT 4'h8

`endif

// ### rtl/cpl_edge_div.v
// rising-edge counting divider for an input from outside the pclk domain
module cpl_edge_div #(
  parameter CW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire sig_in,
  input wire run,
  input wire restart,
  input wire [CW-1:0] ratio,
  output reg pulse,
  output reg [CW-1:0] count
);

  // ---------------------------------------------------------------
  // synchroniser and edge finder
  // ---------------------------------------------------------------
  reg sync1;
  reg sync2;
  reg sync3;
  wire rise;
  wire [CW-1:0] last;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= sig_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;
  // a ratio of zero acts as one
  assign last = (ratio == {CW{1'b0}}) ? {CW{1'b0}} : ratio - {{(CW-1){1'b0}}, 1'b1};

  // ---------------------------------------------------------------
  // counter: one pulse per ratio rising edges
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {CW{1'b0}};
      pulse <= 1'b0;
    end else if (!run || restart) begin
      count <= {CW{1'b0}};
      pulse <= 1'b0;
    end else if (rise) begin
      if (count >= last) begin
        count <= {CW{1'b0}};
        pulse <= 1'b1;
      end else begin
        count <= count + {{(CW-1){1'b0}}, 1'b1};
        pulse <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule // cpl_edge_div

// ### verification/cpl_loop_asserts.sv
// assertion checker for the carrier loop block
module cpl_loop_chk (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire pump_drive_oe_n,
  input wire lock_detect,
  input wire lock_lamp,
  input wire lock_n,
  input wire divided_pulse_or_lock_out,
  input wire mon_square
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------
  // properties
  // ------------------------------
  sequence access_s;
    psel && penable;
  endsequence
  // one-sided pump error well past the window
  sequence pump_stuck_s;
    !pump_drive_oe_n [*7];
  endsequence
  lamp_follow_a: assert property (lock_lamp == lock_detect)
    else $error("lamp differs from lock");
  lock_low_a: assert property (lock_n != lock_detect)
    else $error("lock_n not inverse of lock");
  unlock_a: assert property (pump_stuck_s |-> ##[0:2] !lock_detect)
    else $error("lock kept during long pump error");
  pulse_gap_a: assert property ($rose(divided_pulse_or_lock_out) |=> !divided_pulse_or_lock_out [*3])
    else $error("monitor pulse too long");
  square_toggle_a: assert property ($changed(mon_square) |->
    divided_pulse_or_lock_out || $past(divided_pulse_or_lock_out))
    else $error("square moved without pulse");
  unmapped_err_a: assert property (access_s ##0 (paddr[1:0] == 2'h0) |-> pslverr == (paddr > 8'h1c))
    else $error("error flag wrong for address");
  err_data_a: assert property (access_s ##0 pslverr |-> prdata == 32'h0)
    else $error("data on error response");
  idle_data_a: assert property (!psel |=> prdata == 32'h0)
    else $error("read data left while idle");
endmodule // cpl_loop_chk

bind cpl_loop cpl_loop_chk cpl_loop_chk_inst (.pclk, .presetn, .paddr, .psel, .penable, .prdata, .pslverr,
  .pump_drive_oe_n, .lock_detect, .lock_lamp, .lock_n, .divided_pulse_or_lock_out, .mon_square);

// ### verification/cpl_src.sv
// behavioural reference and rf sources for the loop
module cpl_src (
  input logic run,
  input logic fb_hold,
  input int ref_shift,
  output logic ref_in,
  output logic rf_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_raw = 1'b0;
  logic rf_raw = 1'b0;
  // 6.25 mhz carrier, gated so lines stand low when stopped
  // edges sit 3 ns off the pclk edges so sampling never races them
  always begin
    rf_raw = 1'b0;
    wait (run);
    #3;
    while (run) begin
      #80 rf_raw = 1'b1;
      #80 rf_raw = 1'b0;
    end
  end
  // 200 khz reference, delayed so divided edges meet
  always begin
    ref_raw = 1'b0;
    wait (run);
    #(4923 - ref_shift);
    while (run) begin
      ref_raw = 1'b1;
      #2500 ref_raw = 1'b0;
      #2500;
    end
  end
  assign ref_in = ref_raw & run;
  assign rf_out = rf_raw & run & !fb_hold;
endmodule // cpl_src

// ### verification/tb.sv
// self-checking bench for the carrier loop block
`include "cpl_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LCNT = 2;
  localparam logic [31:0] REF_RATIO = 32'h00030d40 / 32'h0000c350;
  localparam logic [31:0] FB_RATIO = 32'h005f5e10 / 32'h0000c350;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, ref_in, rf, pump_drive_out, pump_drive_oe_n, lock_detect, lock_lamp, lock_n;
  logic divided_pulse_or_lock_out, mon_square, irq, e, m0;
  logic run = 1'b0;
  logic fb_hold = 1'b0;
  logic [2:0] obs;
  int ref_shift = 0;
  int error_cnt = 0;
  int checked = 0;
  int rf_cnt = 0;
  int n;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
  logic [31:0] rv [6] = '{32'h1, 32'h4, 32'h8d4, 32'h500, 32'h0, 32'h0};
  assign obs = {divided_pulse_or_lock_out, pump_drive_oe_n, lock_detect};
  always #5 pclk = ~pclk;
  always @(posedge rf) rf_cnt++;
  cpl_loop #(.LOCK_COUNT(LCNT)) cpl_loop_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .ref_in, .rf_fb_in(rf), .rf_mon_in(rf), .pump_drive_out, .pump_drive_oe_n,
    .lock_detect, .lock_lamp, .lock_n, .divided_pulse_or_lock_out, .mon_square, .irq);
  cpl_src cpl_src_inst (.run, .fb_hold, .ref_shift, .ref_in, .rf_out(rf));
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      $display("FAIL bus answer missing");
      error_cnt++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_bit(input int i, input logic v, input int lim);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      $display("FAIL wait on %0d", i);
      error_cnt++;
      end_of_test();
    end
  endtask
  // stop sources between comparisons, then re-initialise
  task automatic restart(input int sh);
    wait_bit(1, 1'b1, 3000);
    run <= 1'b0;
    repeat (600) @(posedge pclk);
    apb(`CPL_OFF_CTRL, 1'b1, 32'h3);
    ref_shift <= sh;
    run <= 1'b1;
  endtask
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("idle outputs", 32'h0c, {26'h0, lock_detect, lock_lamp, lock_n, pump_drive_oe_n, irq, mon_square});
    for (int i = 0; i < 6; i++) begin
      apb(ra[i], 1'b0, 32'h0);
      chk("reset value", rv[i], q);
    end
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(`CPL_OFF_REF_DIV, 1'b1, REF_RATIO);
    apb(`CPL_OFF_FB_DIV, 1'b1, FB_RATIO);
    apb(`CPL_OFF_MON_DIV, 1'b1, 32'h500);
    ref_shift <= 400;
    run <= 1'b1;
    wait_bit(1, 1'b0, 3000);
    chk("pump on lag", 32'h1, {31'h0, pump_drive_out});
    restart(-400);
    wait_bit(1, 1'b0, 3000);
    chk("pump on lead", 32'h0, {31'h0, pump_drive_out});
    restart(0);
    wait_bit(0, 1'b1, 20000);
    chk("lock delay", 32'h1, {31'h0, n > LCNT * 2000 - 100 && n < LCNT * 2000 + 100});
    chk("lock outputs", 32'h2, {30'h0, lock_lamp, lock_n});
    apb(`CPL_OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("gain flag", 32'h1, q);
    apb(`CPL_OFF_STATUS, 1'b0, 32'h0);
    chk("status locked", 32'h1, q);
    apb(`CPL_OFF_PHASE_ERR, 1'b0, 32'h0);
    chk("phase error", 32'h0, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(`CPL_OFF_IRQ_MASK, 1'b1, 32'h3);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(`CPL_OFF_IRQ_STAT, 1'b1, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wait_bit(2, 1'b1, 25000);
    rf_cnt = 0;
    repeat (2) @(posedge pclk);
    m0 = mon_square;
    wait_bit(2, 1'b1, 25000);
    chk("edges per pulse", 32'h500, rf_cnt);
    repeat (2) @(posedge pclk);
    chk("square toggled", {31'h0, ~m0}, {31'h0, mon_square});
    fb_hold <= 1'b1;
    wait_bit(0, 1'b0, 3000);
    chk("unlock outputs", 32'h1, {30'h0, lock_lamp, lock_n});
    apb(`CPL_OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("loss flag", 32'h2, q);
    chk("irq on loss", 32'h1, {31'h0, irq});
    apb(`CPL_OFF_STATUS, 1'b0, 32'h0);
    chk("pump held up", 32'h2, q);
    apb(`CPL_OFF_CTRL, 1'b1, 32'h0);
    apb(`CPL_OFF_STATUS, 1'b0, 32'h0);
    chk("status disabled", 32'h0, q);
    chk("pump released", 32'h1, {31'h0, pump_drive_oe_n});
    end_of_test();
  end
endmodule // tb
